// ==== sim/serial_far_end.sv ====
/*
  Far side model: trigger and count pins with pull-ups, aux timer overflow
  pulses, and counters of the serial clock ticks coming back.
  Assumes the same clock and reset as the timer; requests are one-cycle.
*/
`timescale 1ns/10ps
module serial_far_end #(
  parameter int LOW_CYC = 16,
  parameter int AUX_PER = 10
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // requests from the bench
  input  wire logic trigReq,
  input  wire logic countReq,
  // serial ticks from the timer
  input  wire logic transmitClockTick,
  input  wire logic receiveClockTick,
  // pins and aux pulse
  output logic      externalTriggerPin,
  output logic      countInputPin,
  output logic      auxTimerOverflow,
  output int        txCount,
  output int        rxCount
);
  int trigLeft;
  int cntLeft;
  int auxCnt;

  // pins idle high through pull-ups, low for over one machine cycle
  assign externalTriggerPin = (trigLeft == 0);
  assign countInputPin      = (cntLeft == 0);

  // pin timers, aux overflow pulse, tick counters
  always_ff @(posedge clock) begin
    if (rst) begin
      trigLeft <= 0; cntLeft <= 0; auxCnt <= 0;
      auxTimerOverflow <= 1'b0; txCount <= 0; rxCount <= 0;
    end else begin
      trigLeft <= trigReq ? LOW_CYC : (trigLeft != 0 ? trigLeft - 1 : 0);
      cntLeft  <= countReq ? LOW_CYC : (cntLeft != 0 ? cntLeft - 1 : 0);
      auxCnt   <= (auxCnt == AUX_PER - 1) ? 0 : auxCnt + 1;
      auxTimerOverflow <= (auxCnt == AUX_PER - 1);
      txCount  <= txCount + int'(transmitClockTick);
      rxCount  <= rxCount + int'(receiveClockTick);
    end
  end
endmodule : serial_far_end

// ==== sim/timer_three_tb.sv ====
/*
  Self-checking bench for the third timer: register port tasks, modes,
  trigger events, pin counting and serial clock selection.
  Assumes the far side model and a 20 MHz clock.
*/
`timescale 1ns/10ps
module timer_three_tb;
  import timer_three_pkg::*;
  localparam int MDIV = 8;
  localparam int LOW  = 16;
  logic       clock    = 1'b0;
  logic       rst      = 1'b1;
  reg_req_s   regReq   = '0;
  logic       trigReq  = 1'b0;
  logic       countReq = 1'b0;
  logic [7:0] readData;
  logic       trigPin, cntPin, auxOvf, txTick, rxTick, overflowFlag, externalEventFlag;
  int         txCount, rxCount, txA, rxA;
  int         mismatches  = 0;
  int         comparisons = 0;
  logic [7:0] modes [3] = '{8'h14, 8'h24, 8'h34};

  // ---------------------------------------------------------------------------
  // clock, design and far side
  // ---------------------------------------------------------------------------
  always #25 clock = ~clock;

  timer_three #(.MACH_DIV(MDIV), .STATE_CNT(2)) uut (
    .clock(clock), .rst(rst), .regReq(regReq), .readData(readData),
    .externalTriggerPin(trigPin), .countInputPin(cntPin), .auxTimerOverflow(auxOvf),
    .transmitClockTick(txTick), .receiveClockTick(rxTick),
    .overflowFlag(overflowFlag), .externalEventFlag(externalEventFlag));

  serial_far_end #(.LOW_CYC(LOW), .AUX_PER(10)) far (
    .clock(clock), .rst(rst), .trigReq(trigReq), .countReq(countReq),
    .transmitClockTick(txTick), .receiveClockTick(rxTick),
    .externalTriggerPin(trigPin), .countInputPin(cntPin), .auxTimerOverflow(auxOvf),
    .txCount(txCount), .rxCount(rxCount));

  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic tally_and_finish;
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock); regReq <= '{1'b1, 1'b0, a, d};
    @(posedge clock); regReq <= '0;
  endtask : wr

  // read, data taken in the cycle after the strobe
  task automatic expect8(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    @(posedge clock); regReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock); regReq <= '0;
    #1 d = readData;
    comparisons++;
    if (d !== e) begin
      mismatches++;
      $display("unexpected read at %0t: got %h expected %h", $time, d, e);
    end
  endtask : expect8

  task automatic expectBit(input logic got, input logic e);
    comparisons++;
    if (got !== e) begin
      mismatches++;
      $display("unexpected flag at %0t: got %h expected %h", $time, got, e);
    end
  endtask : expectBit

  // tick counts may be off by up to two ticks at the window edges
  task automatic expectNear(input int got, input int e);
    comparisons++;
    if (got < e - 2 || got > e + 2) begin
      mismatches++;
      $display("unexpected ticks at %0t: got %h expected %h", $time, got, e);
    end
  endtask : expectNear

  // falling edge on trigger or count pin, then time for pin recovery
  task automatic fire(input bit cnt);
    @(posedge clock);
    if (cnt) countReq <= 1'b1;
    else trigReq <= 1'b1;
    @(posedge clock); countReq <= 1'b0; trigReq <= 1'b0;
    repeat (3 * LOW) @(posedge clock);
    @(negedge clock);
  endtask : fire

  task automatic waitOvf;
    for (int i = 0; i < 64; i++) begin
      @(negedge clock);
      if (overflowFlag === 1'b1) return;
    end
    mismatches++;
    tally_and_finish;
  endtask : waitOvf

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    for (int a = 0; a < 5; a++) expect8(3'(a), 8'h00);
    wr(3'h5, 8'hA5); expect8(3'h5, UNMAPPED_RD);
    wr(OFS_CAP_LO, 8'h5A); wr(OFS_CAP_HI, 8'hC3);
    expect8(OFS_CAP_LO, 8'h5A); expect8(OFS_CAP_HI, 8'hC3);
    wr(OFS_CTRL, 8'h01); repeat (4 * MDIV) @(posedge clock);
    expect8(OFS_CNT_LO, 8'h00);
    wr(OFS_CNT_LO, 8'hFE); wr(OFS_CNT_HI, 8'hFF); wr(OFS_CTRL, 8'h05);
    waitOvf(); expectBit(overflowFlag, 1'b1);
    repeat (4 * MDIV) @(posedge clock);
    @(negedge clock); expectBit(overflowFlag, 1'b1);
    wr(OFS_CTRL, 8'h01); @(negedge clock); expectBit(overflowFlag, 1'b0);
    wr(OFS_CNT_LO, 8'h34); wr(OFS_CNT_HI, 8'h12); wr(OFS_CTRL, 8'h09);
    fire(0); expectBit(externalEventFlag, 1'b1);
    expect8(OFS_CAP_LO, 8'h34); expect8(OFS_CAP_HI, 8'h12);
    expect8(OFS_CNT_LO, 8'h00); expect8(OFS_CNT_HI, 8'h00);
    wr(OFS_CTRL, 8'h01); fire(0); expectBit(externalEventFlag, 1'b0);
    wr(OFS_CAP_LO, 8'hCD); wr(OFS_CAP_HI, 8'hAB);
    wr(OFS_CNT_LO, 8'hFF); wr(OFS_CNT_HI, 8'hFF); wr(OFS_CTRL, 8'h04);
    waitOvf(); wr(OFS_CTRL, 8'h80);
    expect8(OFS_CNT_LO, 8'hCD); expect8(OFS_CNT_HI, 8'hAB);
    wr(OFS_CNT_LO, 8'h10); wr(OFS_CNT_HI, 8'h00); wr(OFS_CTRL, 8'h0C);
    fire(0); expectBit(externalEventFlag, 1'b1);
    wr(OFS_CTRL, 8'h40); expect8(OFS_CNT_HI, 8'hAB);
    wr(OFS_CNT_LO, 8'h34); wr(OFS_CNT_HI, 8'h12); wr(OFS_CTRL, 8'h18);
    fire(0); expectBit(externalEventFlag, 1'b1);
    expect8(OFS_CNT_LO, 8'h34); expect8(OFS_CNT_HI, 8'h12);
    wr(OFS_CNT_LO, 8'h00); wr(OFS_CNT_HI, 8'h00); wr(OFS_CTRL, 8'h06);
    repeat (3) fire(1);
    wr(OFS_CTRL, 8'h00); expect8(OFS_CNT_LO, 8'h03);
    wr(OFS_CAP_LO, 8'hFE); wr(OFS_CAP_HI, 8'hFF); wr(OFS_CNT_LO, 8'hFE); wr(OFS_CNT_HI, 8'hFF);
    // baud modes: timer rollover every 4 clocks, aux every 10
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CTRL, modes[i]);
      txA = txCount; rxA = rxCount;
      repeat (200) @(posedge clock);
      @(negedge clock);
      expectNear(txCount - txA, modes[i][4] ? 50 : 20);
      expectNear(rxCount - rxA, modes[i][5] ? 50 : 20);
      expectBit(overflowFlag, 1'b0);
    end
    tally_and_finish;
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    tally_and_finish;
  end
endmodule : timer_three_tb

// ==== src/edge_sampler.sv ====
/*
  Two-flop synchroniser for a pin, then a falling-edge detector that samples
  once per sample tick. Assumes sampleTick is a one-cycle pulse on this clock.
*/
`timescale 1ns/10ps
module edge_sampler (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // pin and sample strobe
  input  wire logic pin,
  input  wire logic sampleTick,
  // falling edge pulse
  output logic      fall
);
  logic syncA_r;
  logic syncB_r;
  logic prev_r;

  // first flop feeds only the second
  always_ff @(posedge clock) begin
    if (rst) begin
      syncA_r <= 1'b1;
      syncB_r <= 1'b1;
    end else begin
      syncA_r <= pin;
      syncB_r <= syncA_r;
    end
  end

  // high in one sample, low in the next
  always_ff @(posedge clock) begin
    if (rst) begin
      prev_r <= 1'b1;
      fall   <= 1'b0;
    end else begin
      if (sampleTick) prev_r <= syncB_r;
      fall <= sampleTick && prev_r && !syncB_r;
    end
  end
endmodule : edge_sampler

// ==== src/tick_divider.sv ====
/*
  Free running divider giving a one-cycle tick every DIV clocks.
  Assumes a synchronous active-high reset on the same clock.
*/
`timescale 1ns/10ps
module tick_divider #(
  parameter int DIV = 12
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // tick out
  output logic      tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_r;

  // wrap at LAST and pulse on the wrap
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + W'(1);
      tick  <= (cnt_r == LAST);
    end
  end
endmodule : tick_divider

// ==== src/timer_three.sv ====
/*
  Third 16-bit timer/counter with capture, auto-reload and baud rate modes,
  control and data registers behind a plain byte-wide register port.
  Assumes the serial port takes one-cycle clock ticks, the aux timer gives a
  one-cycle overflow pulse on this clock, and both pins are asynchronous.
*/
`timescale 1ns/10ps
module timer_three
  import timer_three_pkg::*;
#(
  parameter int MACH_DIV  = MACHINE_DIV,
  parameter int STATE_CNT = STATE_DIV
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // register port
  input  wire reg_req_s    regReq,
  output logic [7:0]       readData,
  // pins
  input  wire logic        externalTriggerPin,
  input  wire logic        countInputPin,
  // serial port clocking
  input  wire logic        auxTimerOverflow,
  output logic             transmitClockTick,
  output logic             receiveClockTick,
  // flags
  output logic             overflowFlag,
  output logic             externalEventFlag
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  timer_three_control_s ctrl_r;
  timer_three_control_s ctrl_nxt;
  logic [15:0]          count_r;
  logic [15:0]          count_nxt;
  logic [15:0]          reload_r;
  logic [15:0]          reload_nxt;
  logic [7:0]           readData_nxt;
  logic                 txTick_nxt;
  logic                 rxTick_nxt;

  // ---------------------------------------------------------------------------
  // tick sources and pin edges
  // ---------------------------------------------------------------------------
  logic machTick;
  logic stateTick;
  logic trigFall;
  logic pinFall;

  tick_divider #(.DIV(MACH_DIV)) machineDiv (
    .clock (clock),
    .rst   (rst),
    .tick  (machTick)
  );

  tick_divider #(.DIV(STATE_CNT)) stateDiv (
    .clock (clock),
    .rst   (rst),
    .tick  (stateTick)
  );

  edge_sampler triggerEdge (
    .clock      (clock),
    .rst        (rst),
    .pin        (externalTriggerPin),
    .sampleTick (machTick),
    .fall       (trigFall)
  );

  edge_sampler countEdge (
    .clock      (clock),
    .rst        (rst),
    .pin        (countInputPin),
    .sampleTick (machTick),
    .fall       (pinFall)
  );

  // ---------------------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------------------
  wire ctrlWrite  = regReq.write && (regReq.addr == OFS_CTRL);
  wire cntLoWrite = regReq.write && (regReq.addr == OFS_CNT_LO);
  wire cntHiWrite = regReq.write && (regReq.addr == OFS_CNT_HI);
  wire capLoWrite = regReq.write && (regReq.addr == OFS_CAP_LO);
  wire capHiWrite = regReq.write && (regReq.addr == OFS_CAP_HI);
  wire cntWrite   = cntLoWrite || cntHiWrite;
  wire capWrite   = capLoWrite || capHiWrite;

  // ---------------------------------------------------------------------------
  // mode and event decode
  // ---------------------------------------------------------------------------
  mode_e mode;
  wire   baudMode = ctrl_r.receiveClockSelect || ctrl_r.transmitClockSelect;
  assign mode     = baudMode ? MODE_BAUD :
                    (ctrl_r.captureSelect ? MODE_CAPTURE : MODE_RELOAD);

  // internal ticks run at state time in baud mode, machine cycle otherwise
  wire internalTick = baudMode ? stateTick : machTick;
  wire sourceTick   = ctrl_r.countSourceSelect ? pinFall : internalTick;
  wire countTick    = ctrl_r.runControl && sourceTick;
  wire rollover     = countTick && (count_r == COUNT_TOP);
  wire trigEvent    = ctrl_r.externalTriggerEnable && trigFall;
  wire setOverflow  = rollover && (mode != MODE_BAUD);
  wire baudPulse    = rollover && (mode == MODE_BAUD);
  wire [15:0] countInc = count_r + 16'h0001;

  // ---------------------------------------------------------------------------
  // counter next value
  // ---------------------------------------------------------------------------
  always_comb begin
    count_nxt = count_r;
    case (mode)
      MODE_CAPTURE: begin
        if (trigEvent) count_nxt = COUNT_RESET;
        else if (countTick) count_nxt = countInc;
      end
      MODE_RELOAD: begin
        if (rollover || trigEvent) count_nxt = reload_r;
        else if (countTick) count_nxt = countInc;
      end
      MODE_BAUD: begin
        if (rollover) count_nxt = reload_r;
        else if (countTick) count_nxt = countInc;
      end
      default: count_nxt = count_r;
    endcase
    // software write wins over the counter
    if (cntLoWrite) count_nxt[7:0] = regReq.wdata;
    if (cntHiWrite) count_nxt[15:8] = regReq.wdata;
  end

  // ---------------------------------------------------------------------------
  // capture / reload pair next value
  // ---------------------------------------------------------------------------
  always_comb begin
    reload_nxt = reload_r;
    if ((mode == MODE_CAPTURE) && trigEvent) reload_nxt = count_r;
    if (capLoWrite) reload_nxt[7:0] = regReq.wdata;
    if (capHiWrite) reload_nxt[15:8] = regReq.wdata;
  end

  // ---------------------------------------------------------------------------
  // control next value: hardware set wins over a software clear
  // ---------------------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrlWrite ? timer_three_control_s'(regReq.wdata) : ctrl_r;
    if (setOverflow) ctrl_nxt.overflowFlag = 1'b1;
    if (trigEvent) ctrl_nxt.externalEventFlag = 1'b1;
  end

  // ---------------------------------------------------------------------------
  // serial clock selection, each direction on its own
  // ---------------------------------------------------------------------------
  assign txTick_nxt = ctrl_r.transmitClockSelect ? baudPulse : auxTimerOverflow;
  assign rxTick_nxt = ctrl_r.receiveClockSelect ? baudPulse : auxTimerOverflow;

  // ---------------------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------------------
  always_comb begin
    case (regReq.addr)
      OFS_CTRL:   readData_nxt = ctrl_r;
      OFS_CNT_LO: readData_nxt = count_r[7:0];
      OFS_CNT_HI: readData_nxt = count_r[15:8];
      OFS_CAP_LO: readData_nxt = reload_r[7:0];
      OFS_CAP_HI: readData_nxt = reload_r[15:8];
      default:    readData_nxt = UNMAPPED_RD;
    endcase
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r   <= CTRL_RESET;
      count_r  <= COUNT_RESET;
      reload_r <= RELOAD_RESET;
    end else begin
      ctrl_r   <= ctrl_nxt;
      count_r  <= count_nxt;
      reload_r <= reload_nxt;
    end
  end

  // outputs, each from a flop
  always_ff @(posedge clock) begin
    if (rst) begin
      readData          <= 8'h00;
      transmitClockTick <= 1'b0;
      receiveClockTick  <= 1'b0;
    end else begin
      readData          <= regReq.read ? readData_nxt : 8'h00;
      transmitClockTick <= txTick_nxt;
      receiveClockTick  <= rxTick_nxt;
    end
  end

  assign overflowFlag      = ctrl_r.overflowFlag;
  assign externalEventFlag = ctrl_r.externalEventFlag;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence quietBus;
    !regReq.write;
  endsequence

  sequence captureEdge;
    (mode == MODE_CAPTURE) && trigEvent ##0 quietBus;
  endsequence

  sequence baudRoll;
    (mode == MODE_BAUD) && rollover;
  endsequence

  a_source_select: assert property (
    ctrl_r.runControl && ctrl_r.countSourceSelect && !pinFall && !trigEvent ##0 quietBus
    |=> $stable(count_r))
    else $error("counter moved without a pin event");

  a_overflow_set: assert property (
    (mode != MODE_BAUD) && rollover |=> overflowFlag)
    else $error("rollover did not set overflow flag");

  a_capture_copy: assert property (
    captureEdge |=> (reload_r == $past(count_r)))
    else $error("capture did not copy the count");

  a_capture_reset: assert property (
    captureEdge |=> (count_r == COUNT_RESET) && externalEventFlag)
    else $error("capture edge did not reset counter or set event flag");

  a_reload_load: assert property (
    (mode == MODE_RELOAD) && rollover ##0 quietBus |=> (count_r == $past(reload_r)))
    else $error("auto-reload did not load the reload pair");

  a_reload_trigger: assert property (
    (mode == MODE_RELOAD) && trigEvent ##0 quietBus
    |=> (count_r == $past(reload_r)) && externalEventFlag)
    else $error("trigger did not force reload");

  a_baud_reload: assert property (
    baudRoll ##0 quietBus |=> (count_r == $past(reload_r)))
    else $error("baud rollover did not reload");

  a_baud_no_flag: assert property (
    baudRoll ##0 quietBus ##0 !overflowFlag |=> !overflowFlag)
    else $error("baud rollover set overflow flag");

  a_baud_trigger: assert property (
    (mode == MODE_BAUD) && trigEvent && !rollover && !countTick ##0 quietBus
    |=> externalEventFlag && $stable(count_r))
    else $error("baud trigger reloaded or missed event flag");

  a_tx_clock: assert property (
    baudRoll ##0 ctrl_r.transmitClockSelect |=> transmitClockTick)
    else $error("transmit tick missing on baud rollover");

  a_rx_clock: assert property (
    baudRoll ##0 ctrl_r.receiveClockSelect |=> receiveClockTick)
    else $error("receive tick missing on baud rollover");

  a_aux_tx_clock: assert property (
    !ctrl_r.transmitClockSelect && auxTimerOverflow |=> transmitClockTick)
    else $error("transmit tick did not follow aux timer");

  a_aux_clock: assert property (
    !ctrl_r.receiveClockSelect && auxTimerOverflow |=> receiveClockTick)
    else $error("receive tick did not follow aux timer");

  a_flag_sticky: assert property (
    overflowFlag && externalEventFlag ##0 quietBus |=> overflowFlag && externalEventFlag)
    else $error("flag cleared without a software write");

  a_edge_pulse: assert property (
    trigFall |=> !trigFall [*2])
    else $error("trigger edge reported twice in a machine cycle");

  a_read_ctrl: assert property (
    regReq.read && (regReq.addr == OFS_CTRL) |=> (readData == $past(ctrl_r)))
    else $error("control read returned wrong value");

  a_read_idle: assert property (
    !regReq.read |=> (readData == 8'h00))
    else $error("read data shown without a read strobe");

  a_capture_count: assert property (
    (mode == MODE_CAPTURE) && countTick && !trigEvent ##0 quietBus
    |=> (count_r == $past(count_r) + 16'h0001))
    else $error("capture mode counter did not step by one");

  a_timer_source: assert property (
    ctrl_r.runControl && !ctrl_r.countSourceSelect && !internalTick && !trigEvent ##0 quietBus
    |=> $stable(count_r))
    else $error("counter moved without an internal tick");

  a_event_enable: assert property (
    !ctrl_r.externalTriggerEnable && !externalEventFlag ##0 quietBus |=> !externalEventFlag)
    else $error("event flag set with trigger disabled");

endmodule : timer_three

// ==== src/timer_three_pkg.sv ====
/*
  Shared constants and types for the capture / reload / baud timer: register
  offsets, reset values, control field layout, mode encoding, tick dividers.
  Assumes one system clock and a byte-wide register port of the plain kind.
*/
package timer_three_pkg;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W      = 3;
  localparam int          DATA_W      = 8;
  localparam logic [2:0]  OFS_CTRL    = 3'h0;
  localparam logic [2:0]  OFS_CNT_LO  = 3'h1;
  localparam logic [2:0]  OFS_CNT_HI  = 3'h2;
  localparam logic [2:0]  OFS_CAP_LO  = 3'h3;
  localparam logic [2:0]  OFS_CAP_HI  = 3'h4;
  localparam logic [7:0]  UNMAPPED_RD = 8'h00;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [15:0] COUNT_TOP    = 16'hFFFF;

  // ---------------------------------------------------------------------------
  // timing counts: clocks per machine cycle and per state time
  // ---------------------------------------------------------------------------
  localparam int MACHINE_DIV = 12;
  localparam int STATE_DIV   = 2;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  // control byte, bit 7 down to bit 0
  typedef struct packed {
    logic overflowFlag;
    logic externalEventFlag;
    logic receiveClockSelect;
    logic transmitClockSelect;
    logic externalTriggerEnable;
    logic runControl;
    logic countSourceSelect;
    logic captureSelect;
  } timer_three_control_s;

  // one register port request
  typedef struct packed {
    logic              write;
    logic              read;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  typedef enum logic [1:0] {
    MODE_RELOAD  = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_BAUD    = 2'b11
  } mode_e;

endpackage : timer_three_pkg
